// *** rtl/nco_pkg.sv ***
// Constants, register map and types shared by the oscillator files.
package nco_pkg;
  localparam int ACC_W = 20;
  localparam int CNT_W = 8;
  localparam int SRC_N = 10;
  localparam int BYTE_W = 8;
  localparam int DATA_W = 32;
  localparam int ADR_W = 8;

  localparam logic [ADR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] ADDR_CLKSEL = 8'h04;
  localparam logic [ADR_W-1:0] ADDR_ACCL = 8'h08;
  localparam logic [ADR_W-1:0] ADDR_ACCH = 8'h0C;
  localparam logic [ADR_W-1:0] ADDR_ACCU = 8'h10;
  localparam logic [ADR_W-1:0] ADDR_INCL = 8'h14;
  localparam logic [ADR_W-1:0] ADDR_INCH = 8'h18;
  localparam logic [ADR_W-1:0] ADDR_INCU = 8'h1C;
  localparam logic [ADR_W-1:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [ADR_W-1:0] ADDR_IRQ_MASK = 8'h24;

  localparam int BIT_EN = 7;
  localparam int BIT_OUT = 5;
  localparam int BIT_POL = 4;
  localparam int BIT_PFM = 0;
  localparam int PWS_LSB = 5;
  localparam int PWS_MSB = 7;
  localparam int CKS_MSB = 3;
  localparam int UPPER_MSB = 3;
  localparam int IRQ_OVF = 0;

  localparam logic [ACC_W-1:0] ACC_RESET = 20'h00000;
  localparam logic [ACC_W-1:0] INC_RESET = 20'h00001;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;

  localparam logic [3:0] SRC_SYSTEM = 4'h0;
  localparam logic [3:0] SRC_FIRST_EXT = 4'h1;
  localparam logic [3:0] SRC_LAST = 4'hA;

  typedef struct packed {
    logic osc_enable;
    logic output_invert;
    logic pulse_mode_select;
  } osc_ctrl_t;

  typedef struct packed {
    logic [2:0] pulse_width_select;
    logic [3:0] input_clock_select;
  } clk_sel_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } clk_edge_t;

  typedef enum logic [0:0] {OUT_IDLE, OUT_PULSE} pulse_state_t;
endpackage

// *** rtl/clock_edge_select.sv ***
// Input clock selection and edge detection for the oscillator.
`timescale 1ns/1ps
module clock_edge_select (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [nco_pkg::SRC_N-1:0] i_sources,
  input wire logic [3:0] i_select,
  output nco_pkg::clk_edge_t o_edge
);
  import nco_pkg::*;

  logic level;
  logic prev_reg;
  clk_edge_t edge_next;
  clk_edge_t edge_reg;

  // Reserved codes select no source and give no rising edges.
  always_comb begin
    level = 1'b0;
    if (i_select >= SRC_FIRST_EXT && i_select <= SRC_LAST) begin
      level = i_sources[i_select - SRC_FIRST_EXT];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level;
    end
  end

  // The system clock gives one rising and one falling edge per cycle.
  always_comb begin
    edge_next.rise = level & ~prev_reg;
    edge_next.fall = ~level & prev_reg;
    if (i_select == SRC_SYSTEM) begin
      edge_next.rise = 1'b1;
      edge_next.fall = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      edge_reg <= '0;
    end else begin
      edge_reg <= edge_next;
    end
  end

  assign o_edge = edge_reg;
endmodule

// *** rtl/nco_top.sv ***
// Numerically controlled oscillator with a Wishbone register slave.
//
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ps
module nco_top (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [nco_pkg::ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [nco_pkg::DATA_W-1:0] i_wb_dat,
  output logic [nco_pkg::DATA_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [nco_pkg::SRC_N-1:0] i_clk_sources,
  output logic o_nco_out,
  output logic o_overflow,
  output logic o_irq
);
  import nco_pkg::*;

  osc_ctrl_t ctrl_reg;
  clk_sel_t clk_reg;
  clk_edge_t in_edge;
  pulse_state_t state_reg;
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] inc_reg;
  logic [ACC_W-1:0] shadow_reg;
  logic [ACC_W:0] sum;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] width_m1;
  logic [BYTE_W-1:0] rd_byte;
  logic [DATA_W-1:0] dat_reg;
  logic ack_reg;
  logic access;
  logic wr;
  logic pend_reg;
  logic inc_wr_reg;
  logic ovf_now;
  logic ovf_reg;
  logic raw_reg;
  logic out_reg;
  logic status_reg;
  logic mask_reg;
  logic inc_write;

  clock_edge_select edge_sel (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_sources(i_clk_sources),
    .i_select(clk_reg.input_clock_select),
    .o_edge(in_edge)
  );

  // Bus access is taken in the first cycle of a request and acked one cycle later.
  assign access = i_wb_cyc & i_wb_stb & ~ack_reg;
  assign wr = access & i_wb_we & i_wb_sel[0];
  assign inc_write = wr & (i_wb_adr == ADDR_INCL || i_wb_adr == ADDR_INCH || i_wb_adr == ADDR_INCU);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ack_reg <= 1'b0;
      dat_reg <= DATA_ZERO;
    end else begin
      ack_reg <= access;
      if (access) begin
        dat_reg <= {{(DATA_W-BYTE_W){1'b0}}, rd_byte};
      end
    end
  end

  // Unmapped offsets read as zero and ignore writes.
  always_comb begin
    rd_byte = BYTE_ZERO;
    case (i_wb_adr)
      ADDR_CTRL: begin
        rd_byte[BIT_EN] = ctrl_reg.osc_enable;
        rd_byte[BIT_OUT] = out_reg;
        rd_byte[BIT_POL] = ctrl_reg.output_invert;
        rd_byte[BIT_PFM] = ctrl_reg.pulse_mode_select;
      end
      ADDR_CLKSEL: begin
        rd_byte[PWS_MSB:PWS_LSB] = clk_reg.pulse_width_select;
        rd_byte[CKS_MSB:0] = clk_reg.input_clock_select;
      end
      ADDR_ACCL: rd_byte = acc_reg[7:0];
      ADDR_ACCH: rd_byte = acc_reg[15:8];
      ADDR_ACCU: rd_byte[UPPER_MSB:0] = acc_reg[19:16];
      ADDR_INCL: rd_byte = inc_reg[7:0];
      ADDR_INCH: rd_byte = inc_reg[15:8];
      ADDR_INCU: rd_byte[UPPER_MSB:0] = inc_reg[19:16];
      ADDR_IRQ_STATUS: rd_byte[IRQ_OVF] = status_reg;
      ADDR_IRQ_MASK: rd_byte[IRQ_OVF] = mask_reg;
      default: rd_byte = BYTE_ZERO;
    endcase
  end

  assign o_wb_dat = dat_reg;
  assign o_wb_ack = ack_reg;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ctrl_reg <= '0;
      clk_reg <= '0;
      mask_reg <= 1'b0;
    end else if (wr) begin
      if (i_wb_adr == ADDR_CTRL) begin
        ctrl_reg.osc_enable <= i_wb_dat[BIT_EN];
        ctrl_reg.output_invert <= i_wb_dat[BIT_POL];
        ctrl_reg.pulse_mode_select <= i_wb_dat[BIT_PFM];
      end
      if (i_wb_adr == ADDR_CLKSEL) begin
        clk_reg.pulse_width_select <= i_wb_dat[PWS_MSB:PWS_LSB];
        clk_reg.input_clock_select <= i_wb_dat[CKS_MSB:0];
      end
      if (i_wb_adr == ADDR_IRQ_MASK) begin
        mask_reg <= i_wb_dat[IRQ_OVF];
      end
    end
  end

  // Step value bytes.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      inc_reg <= INC_RESET;
    end else if (wr) begin
      if (i_wb_adr == ADDR_INCL) begin
        inc_reg[7:0] <= i_wb_dat[7:0];
      end
      if (i_wb_adr == ADDR_INCH) begin
        inc_reg[15:8] <= i_wb_dat[7:0];
      end
      if (i_wb_adr == ADDR_INCU) begin
        inc_reg[19:16] <= i_wb_dat[UPPER_MSB:0];
      end
    end
  end

  // Shadow loading: on a falling input edge after a low-byte write while running, one cycle after a step write while stopped.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      pend_reg <= 1'b0;
      inc_wr_reg <= 1'b0;
      shadow_reg <= INC_RESET;
    end else begin
      inc_wr_reg <= inc_write;
      if (wr && i_wb_adr == ADDR_INCL && ctrl_reg.osc_enable) begin
        pend_reg <= 1'b1;
      end else if (in_edge.fall) begin
        pend_reg <= 1'b0;
      end
      if (!ctrl_reg.osc_enable && inc_wr_reg) begin
        shadow_reg <= inc_reg;
      end else if (ctrl_reg.osc_enable && pend_reg && in_edge.fall) begin
        shadow_reg <= inc_reg;
      end
    end
  end

  assign sum = {1'b0, acc_reg} + {1'b0, shadow_reg};
  assign ovf_now = ctrl_reg.osc_enable & in_edge.rise & sum[ACC_W];

  // Accumulator; a bus write while running gives an undefined phase.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      acc_reg <= ACC_RESET;
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_now;
      if (wr && i_wb_adr == ADDR_ACCL) begin
        acc_reg[7:0] <= i_wb_dat[7:0];
      end else if (wr && i_wb_adr == ADDR_ACCH) begin
        acc_reg[15:8] <= i_wb_dat[7:0];
      end else if (wr && i_wb_adr == ADDR_ACCU) begin
        acc_reg[19:16] <= i_wb_dat[UPPER_MSB:0];
      end else if (ctrl_reg.osc_enable && in_edge.rise) begin
        acc_reg <= sum[ACC_W-1:0];
      end
    end
  end

  assign width_m1 = (CNT_ONE << clk_reg.pulse_width_select) - CNT_ONE;

  // Output shaping in both modes.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      raw_reg <= 1'b0;
      cnt_reg <= CNT_ZERO;
      state_reg <= OUT_IDLE;
    end else if (!ctrl_reg.osc_enable) begin
      raw_reg <= 1'b0;
      cnt_reg <= CNT_ZERO;
      state_reg <= OUT_IDLE;
    end else if (!ctrl_reg.pulse_mode_select) begin
      state_reg <= OUT_IDLE;
      if (ovf_now) begin
        raw_reg <= ~raw_reg;
      end
    end else begin
      case (state_reg)
        OUT_IDLE: begin
          if (ovf_now) begin
            raw_reg <= 1'b1;
            cnt_reg <= width_m1;
            state_reg <= OUT_PULSE;
          end else begin
            raw_reg <= 1'b0;
          end
        end
        OUT_PULSE: begin
          if (ovf_now) begin
            cnt_reg <= width_m1;
          end else if (in_edge.rise) begin
            if (cnt_reg == CNT_ZERO) begin
              raw_reg <= 1'b0;
              state_reg <= OUT_IDLE;
            end else begin
              cnt_reg <= cnt_reg - CNT_ONE;
            end
          end
        end
        default: begin
          raw_reg <= 1'b0;
          state_reg <= OUT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= raw_reg ^ ctrl_reg.output_invert;
    end
  end

  // Sticky overflow flag, write one to clear; a new overflow wins over the clear.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      status_reg <= 1'b0;
    end else if (ovf_reg) begin
      status_reg <= 1'b1;
    end else if (wr && i_wb_adr == ADDR_IRQ_STATUS && i_wb_dat[IRQ_OVF]) begin
      status_reg <= 1'b0;
    end
  end

  assign o_nco_out = out_reg;
  assign o_overflow = ovf_reg;
  assign o_irq = status_reg & mask_reg;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  ack_single_cycle_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  acc_hold_stopped_a: assert property (!ctrl_reg.osc_enable && !wr |=> $stable(acc_reg))
    else $error("accumulator moved while stopped");
  status_bit_read_a: assert property (access && !i_wb_we && i_wb_adr == ADDR_CTRL
      |=> o_wb_ack && o_wb_dat[BIT_OUT] == $past(out_reg))
    else $error("output status bit wrong");
  polarity_out_a: assert property (##1 o_nco_out == ($past(raw_reg) ^ $past(ctrl_reg.output_invert)))
    else $error("output polarity wrong");
  fdc_toggle_a: assert property (ovf_now && !ctrl_reg.pulse_mode_select |=> raw_reg != $past(raw_reg))
    else $error("no toggle on overflow");
  pulse_start_a: assert property (ovf_now && ctrl_reg.pulse_mode_select |=> raw_reg && state_reg == OUT_PULSE)
    else $error("pulse did not start");
  pulse_end_a: assert property (ctrl_reg.osc_enable && ctrl_reg.pulse_mode_select && state_reg == OUT_PULSE
      && in_edge.rise && cnt_reg == CNT_ZERO && !ovf_now |=> !raw_reg)
    else $error("pulse did not end");
  upper_zero_a: assert property (access && !i_wb_we && i_wb_adr == ADDR_ACCU |=> o_wb_dat[7:4] == 4'h0)
    else $error("upper accumulator bits not zero");
  acc_add_a: assert property (ctrl_reg.osc_enable && in_edge.rise && !wr
      |=> acc_reg == ACC_W'($past(acc_reg) + $past(shadow_reg)))
    else $error("accumulator sum wrong");
  flag_set_a: assert property (ovf_now |=> ##1 status_reg)
    else $error("overflow flag not set");
  shadow_fall_a: assert property (ctrl_reg.osc_enable && pend_reg && in_edge.fall
      |=> shadow_reg == $past(inc_reg))
    else $error("shadow not loaded on falling edge");
  shadow_stopped_a: assert property (!ctrl_reg.osc_enable && inc_wr_reg |=> shadow_reg == $past(inc_reg))
    else $error("shadow not loaded while stopped");

  ack_follows_a: assert property (access |=> o_wb_ack)
    else $error("request not acknowledged");
  read_high_zero_a: assert property (access && !i_wb_we |=> o_wb_dat[DATA_W-1:BYTE_W] == '0)
    else $error("read data upper bits not zero");
  status_clear_a: assert property (wr && i_wb_adr == ADDR_IRQ_STATUS && i_wb_dat[IRQ_OVF] && !ovf_reg
      |=> !status_reg)
    else $error("overflow flag not cleared");
  flag_sticky_a: assert property (status_reg
      && !(wr && i_wb_adr == ADDR_IRQ_STATUS && i_wb_dat[IRQ_OVF]) |=> status_reg)
    else $error("overflow flag dropped");
  ovf_pulse_a: assert property (ovf_now |=> o_overflow)
    else $error("overflow pulse missing");
  stopped_out_low_a: assert property (!ctrl_reg.osc_enable |=> !raw_reg)
    else $error("output active while stopped");
  fdc_hold_a: assert property (ctrl_reg.osc_enable && !ctrl_reg.pulse_mode_select
      && !ovf_now |=> $stable(raw_reg))
    else $error("toggle without overflow");
  fdc_idle_a: assert property (ctrl_reg.osc_enable && !ctrl_reg.pulse_mode_select
      |=> state_reg == OUT_IDLE)
    else $error("pulse state in fixed duty mode");
  pulse_restart_a: assert property (ovf_now && ctrl_reg.pulse_mode_select && state_reg == OUT_PULSE
      |=> raw_reg && cnt_reg == $past(width_m1))
    else $error("pulse not restarted");
  pulse_count_a: assert property (ctrl_reg.osc_enable && ctrl_reg.pulse_mode_select && state_reg == OUT_PULSE
      && in_edge.rise && !ovf_now && cnt_reg != CNT_ZERO |=> cnt_reg == CNT_W'($past(cnt_reg) - CNT_ONE))
    else $error("pulse counter did not step");
  reserved_no_edge_a: assert property (clk_reg.input_clock_select > SRC_LAST |=> !in_edge.rise)
    else $error("edge from reserved source");
  sys_clock_edge_a: assert property (clk_reg.input_clock_select == SRC_SYSTEM
      |=> in_edge.rise && in_edge.fall)
    else $error("system clock edge missing");
  acc_write_a: assert property (wr && i_wb_adr == ADDR_ACCL |=> acc_reg[7:0] == $past(i_wb_dat[7:0]))
    else $error("accumulator write lost");
  step_write_a: assert property (wr && i_wb_adr == ADDR_INCL |=> inc_reg[7:0] == $past(i_wb_dat[7:0]))
    else $error("step write lost");
  pend_clear_a: assert property (ctrl_reg.osc_enable && pend_reg && in_edge.fall
      && !(wr && i_wb_adr == ADDR_INCL) |=> !pend_reg)
    else $error("pending load not cleared");

  stopped_load_c: cover property (!ctrl_reg.osc_enable && inc_wr_reg);
  pulse_seen_c: cover property (state_reg == OUT_IDLE ##1 state_reg == OUT_PULSE);
  toggle_seen_c: cover property (ovf_now && !ctrl_reg.pulse_mode_select);
  irq_seen_c: cover property (o_irq);
  shadow_seen_c: cover property (ctrl_reg.osc_enable && pend_reg && in_edge.fall);
endmodule

// *** tb/nco_top_tb.sv ***
// Self-checking testbench for the numerically controlled oscillator.
`timescale 1ns/1ps
module nco_top_tb;
  import nco_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [DATA_W-1:0] wdat = 32'h00000000;
  logic [DATA_W-1:0] rdat;
  logic ack;
  logic nco_out;
  logic ovf;
  logic irq;
  logic [SRC_N-1:0] src = 10'h000;
  logic [DATA_W-1:0] exp_q[$];
  logic [31:0] seed = 32'h00013537;
  logic prev_out = 1'b0;
  int n_fail = 0;
  int checks = 0;
  int n_ovf = 0;
  int n_tog = 0;
  int n_hi = 0;

  always #50 i_clk_sys = ~i_clk_sys;

  nco_top i_nco_top (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_clk_sources(src), .o_nco_out(nco_out), .o_overflow(ovf), .o_irq(irq));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Read data is compared against the oldest expectation noted by the driver.
  task automatic cmp_rd(input logic [31:0] got);
    logic [31:0] e;
    e = (exp_q.size() == 0) ? ~got : exp_q.pop_front();
    cmp_val(got, e, "read data");
  endtask

  always @(posedge i_clk_sys) begin
    if (ack === 1'b1 && we === 1'b0) begin
      cmp_rd(rdat);
    end
    if (ovf === 1'b1) n_ovf++;
    if (nco_out !== prev_out) n_tog++;
    if (nco_out === 1'b1) n_hi++;
    prev_out = nco_out;
  end

  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {seed[31:8], d};
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) cmp_val(32'h00000000, 32'h00000001, "bus answer");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(a, 1'b1, d, 4'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    wb(a, 1'b0, 8'h00, 4'h1);
  endtask

  // Each rise of the selected source is held one cycle high and one low.
  task automatic rises(input int k, input logic [SRC_N-1:0] m);
    repeat (k) begin
      @(posedge i_clk_sys);
      src <= m;
      @(posedge i_clk_sys);
      src <= 10'h000;
    end
    repeat (6) @(posedge i_clk_sys);
  endtask

  task automatic clr();
    @(negedge i_clk_sys);
    n_ovf = 0;
    n_tog = 0;
    n_hi = 0;
    prev_out = nco_out;
  endtask

  task automatic do_reset(input int cycles);
    @(posedge i_clk_sys);
    i_reset <= 1'b1;
    repeat (cycles) @(posedge i_clk_sys);
    i_reset <= 1'b0;
  endtask

  initial begin
    #2000000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    logic [19:0] step;
    logic [31:0] prod;
    logic [3:0] code;
    logic [2:0] w;
    logic pol;
    logic [SRC_N-1:0] m;
    int ov;
    do_reset(20);
    rd(ADDR_CTRL, 8'h00);
    rd(ADDR_CLKSEL, 8'h00);
    rd(ADDR_INCL, 8'h01);
    rd(ADDR_INCH, 8'h00);
    rd(ADDR_ACCU, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h00);
    wr(8'h28, 8'h5A);
    rd(8'h28, 8'h00);
    wr(ADDR_CTRL, 8'h20);
    rd(ADDR_CTRL, 8'h00);
    wb(ADDR_CTRL, 1'b1, 8'h80, 4'h0);
    rd(ADDR_CTRL, 8'h00);
    // Fixed duty cycle runs over source codes 1 to 15, reserved ones included.
    for (int c = 1; c < 16; c++) begin
      code = 4'(c);
      seed = lfsr(seed);
      step = seed[19:0] | 20'h80000;
      w = seed[22:20];
      pol = code[0];
      m = (c <= 10) ? (10'h001 << (c - 1)) : 10'h3FF;
      prod = 32'(step) * 32'h0000000C;
      ov = (c <= 10) ? int'(prod[31:20]) : 0;
      if (c > 10) prod = 32'h00000000;
      do_reset(2);
      wr(ADDR_INCU, {4'h0, step[19:16]});
      wr(ADDR_INCH, step[15:8]);
      wr(ADDR_INCL, step[7:0]);
      rd(ADDR_INCU, {4'h0, step[19:16]});
      rd(ADDR_INCH, step[15:8]);
      rd(ADDR_INCL, step[7:0]);
      wr(ADDR_CLKSEL, {w, 1'b0, code});
      rd(ADDR_CLKSEL, {w, 1'b0, code});
      wr(ADDR_CTRL, {1'b1, 2'b00, pol, 4'h0});
      clr();
      rises(12, m);
      cmp_val(n_ovf, ov, "overflow count");
      cmp_val(n_tog, ov, "output toggles");
      cmp_val(nco_out, ov[0] ^ pol, "output level");
      rd(ADDR_CTRL, {1'b1, 1'b0, ov[0] ^ pol, pol, 4'h0});
      wr(ADDR_CTRL, {3'b000, pol, 4'h0});
      rises(3, m);
      rd(ADDR_ACCL, prod[7:0]);
      rd(ADDR_ACCH, prod[15:8]);
      rd(ADDR_ACCU, {4'h0, prod[19:16]});
      rd(ADDR_IRQ_STATUS, {7'h00, ov != 0});
      cmp_val(irq, 32'h00000000, "masked interrupt");
      wr(ADDR_IRQ_MASK, 8'h01);
      cmp_val(irq, ov != 0, "interrupt level");
      wr(ADDR_IRQ_STATUS, 8'h01);
      cmp_val(irq, 32'h00000000, "cleared interrupt");
      rd(ADDR_IRQ_STATUS, 8'h00);
    end
    // Pulse mode with every width code; one overflow after eight rises.
    for (int k = 0; k < 8; k++) begin
      w = 3'(k);
      do_reset(2);
      wr(ADDR_INCH, 8'h10);
      wr(ADDR_INCL, 8'h00);
      wr(ADDR_ACCU, 8'h0F);
      wr(ADDR_ACCH, 8'h80);
      rd(ADDR_ACCU, 8'h0F);
      rd(ADDR_ACCH, 8'h80);
      wr(ADDR_CLKSEL, {w, 5'h01});
      wr(ADDR_CTRL, 8'h81);
      clr();
      rises(12 + (1 << k), 10'h001);
      cmp_val(n_ovf, 32'h00000001, "pulse mode overflow");
      cmp_val(n_hi, 2 << k, "pulse width");
    end
    // A step written while running takes effect only after a falling input edge.
    do_reset(2);
    wr(ADDR_CLKSEL, 8'h01);
    wr(ADDR_CTRL, 8'h80);
    wr(ADDR_INCL, 8'h10);
    rises(3, 10'h001);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_ACCL, 8'h21);
    // Code zero adds on every system clock while enabled.
    do_reset(2);
    wr(ADDR_CTRL, 8'h80);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_ACCL, 8'h03);
    repeat (4) @(posedge i_clk_sys);
    give_verdict();
  end
endmodule
